// ### shared/card_ctl_pkg.sv
// Package: constants and carrier types for the card supply, aux line and clock control block
package card_ctl_pkg;

    // ------------------------------------------------------------------
    // Clock divider modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DIV_BY_1 = 2'b00,
        DIV_BY_2 = 2'b01,
        DIV_BY_4 = 2'b10,
        DIV_STOP = 2'b11
    } clk_div_t;

    // ------------------------------------------------------------------
    // Power-down sequence states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PD_IDLE  = 3'b000,
        PD_RST   = 3'b001,
        PD_CLK   = 3'b010,
        PD_IO    = 3'b011,
        PD_VCC   = 3'b100,
        PD_OFF   = 3'b101
    } pd_state_t;

    // ------------------------------------------------------------------
    // Status byte layout
    // ------------------------------------------------------------------
    localparam int STAT_HIGH_ID_BIT = 0;
    localparam int STAT_LOW_ID_BIT  = 1;
    localparam int STAT_LOW_V_BIT   = 2;
    localparam int STAT_OVLD_BIT    = 3;
    localparam int STAT_DET_BIT     = 4;

    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [1:0] DIV_CNT_RESET = 2'h0;

    // Power-down step time, converted to clock cycles
    localparam int CLOCK_MHZ        = 25;
    localparam int PD_STEP_NS       = 200;
    localparam int PD_STEP_CYC      = (PD_STEP_NS * CLOCK_MHZ) / 1000;
    localparam logic [7:0] PD_STEP_CNT = 8'(PD_STEP_CYC);

    // Settings from the host command byte
    typedef struct packed {
        logic       supply_on;   // Request card supply on
        clk_div_t   div_mode;    // Card clock rate
        logic       fast_edges;  // Card clock edge speed
        logic       sync_mode;   // Synchronous card in use
        logic       aux_high_wr; // High aux line level written to card
        logic       aux_low_wr;  // Low aux line level written to card
    } card_cfg_t;

    // Analog supervisor inputs
    typedef struct packed {
        logic supply_low;     // At or below low-voltage threshold
        logic supply_ovld;    // Overload detected
        logic supply_ready;   // Startup sequence complete, supply up
        logic card_present;   // Card detect, already filtered
    } supply_mon_t;

endpackage

// ### core/card_supply_aux_clock_control.sv
// Card supply supervision, aux line access and card clock gating
`timescale 1ns/1ps

module card_supply_aux_clock_control
    import card_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // Host settings and status access
    input  wire card_cfg_t   cfg,
    input  wire logic        status_rd,
    output logic [7:0]       status,
    output logic             int_n,
    // Supply supervisor and converter control
    input  wire supply_mon_t mon,
    output logic             conv_en,
    output logic             card_rst_low,
    output logic             io_low,
    // Auxiliary lines, open drain, enable low while driving low
    input  wire logic        aux_line_high_id_in,
    output logic             aux_line_high_id_out,
    output logic             aux_line_high_id_oe_n,
    input  wire logic        aux_line_low_id_in,
    output logic             aux_line_low_id_out,
    output logic             aux_line_low_id_oe_n,
    // Card clock
    output logic             card_clock_out,
    output logic             card_clock_fast
);

    // ------------------------------------------------------------------
    // Status flags and interrupt
    // ------------------------------------------------------------------
    logic       low_v_q, low_v_d;
    logic       ovld_q, ovld_d;
    logic       ovld_prev_q, ovld_prev_d;
    logic       det_prev_q, det_prev_d;
    logic       det_seen_q, det_seen_d;
    logic       int_q, int_d;
    logic [7:0] status_q, status_d;
    logic       aux_hi_rd, aux_lo_rd;

    // Aux read value: driven level in sync mode, pin level otherwise
    always_comb
    begin
        aux_hi_rd = cfg.sync_mode ? cfg.aux_high_wr : aux_line_high_id_in;
        aux_lo_rd = cfg.sync_mode ? cfg.aux_low_wr  : aux_line_low_id_in;
    end

    // Sticky flags; a new event in the read cycle wins over the clear
    always_comb
    begin
        ovld_prev_d = mon.supply_ovld;
        det_prev_d  = mon.card_present;
        det_seen_d  = 1'b1; // Arms card detect edges one cycle after reset
        low_v_d     = status_rd ? 1'b0 : low_v_q;
        ovld_d      = status_rd ? 1'b0 : ovld_q;
        int_d       = status_rd ? 1'b0 : int_q;
        if (mon.supply_low)
            low_v_d = 1'b1;
        if (mon.supply_ovld)
            ovld_d = 1'b1;
        // A card already seated at reset release must not look like an insertion
        if ((mon.supply_ovld && !ovld_prev_q)
            || (det_seen_q && (mon.card_present != det_prev_q)))
            int_d = 1'b1;
        status_d = STATUS_RESET;
        status_d[STAT_HIGH_ID_BIT] = aux_hi_rd;
        status_d[STAT_LOW_ID_BIT]  = aux_lo_rd;
        status_d[STAT_LOW_V_BIT]   = low_v_d;
        status_d[STAT_OVLD_BIT]    = ovld_d;
        status_d[STAT_DET_BIT]     = mon.card_present;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            low_v_q     <= 1'b0;
            ovld_q      <= 1'b0;
            ovld_prev_q <= 1'b0;
            det_prev_q  <= 1'b0;
            det_seen_q  <= 1'b0;
            int_q       <= 1'b0;
            status_q    <= STATUS_RESET;
        end
        else
        begin
            low_v_q     <= low_v_d;
            ovld_q      <= ovld_d;
            ovld_prev_q <= ovld_prev_d;
            det_prev_q  <= det_prev_d;
            det_seen_q  <= det_seen_d;
            int_q       <= int_d;
            status_q    <= status_d;
        end
    end

    assign status = status_q;
    assign int_n  = ~int_q;

    // ------------------------------------------------------------------
    // Overload power-down sequence
    // ------------------------------------------------------------------
    pd_state_t  pd_q, pd_d;
    logic [7:0] pd_cnt_q, pd_cnt_d;
    logic       conv_q, conv_d;

    // Reset low, clock stop, I/O low, then converter off; step spacing fixed
    always_comb
    begin
        pd_d     = pd_q;
        pd_cnt_d = pd_cnt_q;
        conv_d   = conv_q;
        unique case (pd_q)
            PD_IDLE:
            begin
                conv_d = cfg.supply_on;
                if (mon.supply_ovld && conv_q)
                begin
                    pd_d     = PD_RST;
                    pd_cnt_d = PD_STEP_CNT;
                end
            end
            PD_RST, PD_CLK, PD_IO:
            begin
                if (pd_cnt_q == 8'h00)
                begin
                    pd_d     = pd_state_t'(pd_q + 3'h1);
                    pd_cnt_d = PD_STEP_CNT;
                end
                else
                    pd_cnt_d = pd_cnt_q - 8'h01;
            end
            PD_VCC:
            begin
                conv_d = 1'b0;
                pd_d   = PD_OFF;
            end
            PD_OFF:
            begin
                conv_d = 1'b0;
                if (!cfg.supply_on)
                    pd_d = PD_IDLE; // Host must drop the request to restart
            end
            default:
                pd_d = PD_OFF;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pd_q     <= PD_IDLE;
            pd_cnt_q <= 8'h00;
            conv_q   <= 1'b0;
        end
        else
        begin
            pd_q     <= pd_d;
            pd_cnt_q <= pd_cnt_d;
            conv_q   <= conv_d;
        end
    end

    assign conv_en      = conv_q;
    assign card_rst_low = (pd_q != PD_IDLE);
    assign io_low       = (pd_q >= PD_IO);

    // Aux lines: open drain pulls low only when writing a zero in sync mode
    assign aux_line_high_id_out  = 1'b0;
    assign aux_line_high_id_oe_n = ~(cfg.sync_mode && !cfg.aux_high_wr && conv_q);
    assign aux_line_low_id_out   = 1'b0;
    assign aux_line_low_id_oe_n  = ~(cfg.sync_mode && !cfg.aux_low_wr && conv_q);

    // ------------------------------------------------------------------
    // Card clock selection and gating
    // ------------------------------------------------------------------
    logic [1:0] div_cnt_q, div_cnt_d;
    logic       clk_q, clk_d;
    logic       fast_q, fast_d;
    logic       clk_run;

    assign clk_run = conv_q && mon.supply_ready && (pd_q < PD_CLK);

    // Toggle output at enable rate; divide by one follows the cycle parity
    always_comb
    begin
        div_cnt_d = div_cnt_q + 2'h1;
        fast_d    = cfg.fast_edges;
        clk_d     = clk_q;
        unique case (cfg.div_mode)
            DIV_BY_1: clk_d = ~clk_q;
            DIV_BY_2: clk_d = div_cnt_q[0] ? ~clk_q : clk_q;
            DIV_BY_4: clk_d = (div_cnt_q == 2'h3) ? ~clk_q : clk_q;
            DIV_STOP: clk_d = 1'b0;
        endcase
        if (!clk_run)
        begin
            clk_d     = 1'b0;
            div_cnt_d = DIV_CNT_RESET;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            div_cnt_q <= DIV_CNT_RESET;
            clk_q     <= 1'b0;
            fast_q    <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_cnt_d;
            clk_q     <= clk_d;
            fast_q    <= fast_d;
        end
    end

    assign card_clock_out  = clk_q;
    assign card_clock_fast = fast_q;

endmodule

// ### bench/card_ctl_checker.sv
// Port checks for the card supply, aux line and clock control block
`timescale 1ns/1ps
module card_ctl_checker
    import card_ctl_pkg::*;
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // Watched ports
    input wire card_cfg_t   cfg,
    input wire logic [7:0]  status,
    input wire logic        int_n,
    input wire supply_mon_t mon,
    input wire logic        conv_en,
    input wire logic        card_rst_low,
    input wire logic        aux_line_high_id_in,
    input wire logic        aux_line_low_id_in,
    input wire logic        card_clock_out,
    input wire logic        card_clock_fast
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Card clock may run only with the supply up
    logic run;
    assign run = conv_en & mon.supply_ready;
    // Supply faults
    chk_low_flag: assert property (mon.supply_low |=> status[2])
        else $error("low flag not set");
    chk_low_runs: assert property (conv_en && cfg.supply_on && mon.supply_low
        && !mon.supply_ovld && !card_rst_low |=> conv_en) else $error("converter stopped");
    chk_ovld_flag: assert property (mon.supply_ovld && conv_en |=> status[3] && !int_n)
        else $error("overload not flagged");
    chk_ovld_off: assert property (mon.supply_ovld && conv_en |-> ##[2:100] !conv_en)
        else $error("converter not stopped");
    // Aux line read back
    chk_high_bit: assert property (1 |=> status[0] == ($past(cfg.sync_mode) ?
        $past(cfg.aux_high_wr) : $past(aux_line_high_id_in))) else $error("bit 0 wrong");
    chk_low_bit: assert property (1 |=> status[1] == ($past(cfg.sync_mode) ?
        $past(cfg.aux_low_wr) : $past(aux_line_low_id_in))) else $error("bit 1 wrong");
    // Card clock
    chk_clk_gate: assert property (!run |=> !card_clock_out)
        else $error("clock not held low");
    chk_edge_speed: assert property (1 |=> card_clock_fast == $past(cfg.fast_edges))
        else $error("edge speed wrong");
    chk_div_two: assert property ((run && !card_rst_low && cfg.div_mode == DIV_BY_2) [*8]
        |-> card_clock_out != $past(card_clock_out, 2)) else $error("half rate wrong");
    // Main scenarios reached
    cov_ovld: cover property (mon.supply_ovld && conv_en);
    cov_sync: cover property (cfg.sync_mode && run);
    cov_quarter: cover property (run && cfg.div_mode == DIV_BY_4);
endmodule

bind card_supply_aux_clock_control card_ctl_checker chk (.*);

// ### bench/card_model.sv
// Card side of the aux lines: open-drain wires pulled up to the card supply
`timescale 1ns/1ps
module card_model
(
    // Block enables, low while pulling low
    input  wire logic hi_oe_n,
    input  wire logic lo_oe_n,
    // Card contact tied to ground when high
    input  wire logic hi_gnd,
    input  wire logic lo_gnd,
    // Resolved wire levels
    output logic      hi_lvl,
    output logic      lo_lvl
);
    // Pull-up wins unless a party pulls low
    assign hi_lvl = hi_oe_n & ~hi_gnd;
    assign lo_lvl = lo_oe_n & ~lo_gnd;
endmodule

// ### bench/card_supply_aux_clock_control_bench.sv
// Self-checking bench for the card supply, aux line and clock control block
`timescale 1ns/1ps
module card_supply_aux_clock_control_bench;
    import card_ctl_pkg::*;
    logic        clock, nrst, status_rd, int_n, conv_en, rst_low, io_low, clk_o, fast;
    logic        hi_in, hi_oe_n, lo_in, lo_oe_n, hi_gnd, lo_gnd, p;
    logic [7:0]  status;
    card_cfg_t   cfg;
    supply_mon_t mon;
    int          mismatches, n_checks, n;

    card_supply_aux_clock_control DUT (.clock(clock), .nrst(nrst), .cfg(cfg),
        .status_rd(status_rd), .status(status), .int_n(int_n), .mon(mon), .conv_en(conv_en),
        .card_rst_low(rst_low), .io_low(io_low), .aux_line_high_id_in(hi_in),
        .aux_line_high_id_out(), .aux_line_high_id_oe_n(hi_oe_n), .aux_line_low_id_in(lo_in),
        .aux_line_low_id_out(), .aux_line_low_id_oe_n(lo_oe_n), .card_clock_out(clk_o),
        .card_clock_fast(fast));
    card_model card (.hi_oe_n(hi_oe_n), .lo_oe_n(lo_oe_n), .hi_gnd(hi_gnd), .lo_gnd(lo_gnd),
        .hi_lvl(hi_in), .lo_lvl(lo_in));

    // 25 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Bounded wait on the converter enable
    task automatic wait_conv(input logic v);
        for (int i = 0; i < 200 && conv_en !== v; i++)
            cyc(1);
        if (conv_en !== v)
        begin
            mismatches++;
            $display("ERROR %0t: converter enable wait timed out", $time);
            test_done();
        end
    endtask
    task automatic read_status;
        status_rd = 1'b1;
        cyc(1);
        status_rd = 1'b0;
        cyc(1);
    endtask
    // Aux lines: pin level when async, written level when sync
    task automatic s_aux;
        for (int k = 0; k < 4; k++)
        begin
            cfg.sync_mode = 1'b0;
            {lo_gnd, hi_gnd} = k[1:0];
            cyc(3);
            check({6'h00, status[1:0]}, {6'h00, ~k[1:0]});
            cfg.sync_mode = 1'b1;
            {cfg.aux_low_wr, cfg.aux_high_wr} = k[1:0];
            {lo_gnd, hi_gnd} = ~k[1:0];
            cyc(3);
            check({6'h00, status[1:0]}, {6'h00, k[1:0]});
        end
        cfg.sync_mode = 1'b0;
        {lo_gnd, hi_gnd} = 2'b00;
    endtask
    // Clock held low until supply ready, then every divider mode
    task automatic s_clock;
        cfg.supply_on = 1'b1;
        wait_conv(1'b1);
        // Sync write of zero pulls only that line low while the supply is up
        cfg.sync_mode = 1'b1;
        cfg.aux_low_wr = 1'b1;
        cfg.aux_high_wr = 1'b0;
        cyc(1);
        check({6'h00, lo_oe_n, hi_oe_n}, 8'h02);
        cfg.sync_mode = 1'b0;
        cyc(4);
        check({7'h00, clk_o}, 8'h00);
        mon.supply_ready = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            cfg.div_mode = clk_div_t'(m);
            cfg.fast_edges = m[0];
            cyc(8);
            check({7'h00, fast}, {7'h00, m[0]});
            n = 0;
            for (int j = 0; j < 16; j++)
            begin
                p = clk_o;
                cyc(1);
                n += int'(clk_o != p);
            end
            check(8'(n), 8'((m == 3) ? 0 : (16 >> m)));
        end
    endtask
    // Low supply flag, card removal interrupt, clear on read
    task automatic s_low;
        mon.supply_low = 1'b1;
        cyc(1);
        mon.supply_low = 1'b0;
        cyc(3);
        check({6'h00, status[2], conv_en}, 8'h03);
        read_status();
        check({7'h00, status[2]}, 8'h00);
        mon.card_present = 1'b0;
        cyc(2);
        check({6'h00, int_n, status[4]}, 8'h00);
        read_status();
        check({7'h00, int_n}, 8'h01);
    endtask
    // Overload stops converter through the power-down steps
    task automatic s_ovld;
        cfg.div_mode = DIV_BY_1;
        mon.supply_ovld = 1'b1;
        cyc(1);
        mon.supply_ovld = 1'b0;
        cyc(1);
        check({6'h00, status[3], int_n}, 8'h02);
        // Running clock must be stopped before the I/O step
        for (int i = 0; i < 40 && io_low !== 1'b1; i++)
            cyc(1);
        check({6'h00, io_low, clk_o}, 8'h02);
        wait_conv(1'b0);
        mon.supply_ready = 1'b0;
        cyc(4);
        check({4'h0, conv_en, io_low, rst_low, clk_o}, 8'h06);
        check({7'h00, status[3]}, 8'h01);
        read_status();
        check({7'h00, status[3]}, 8'h00);
        // Restart after power-down needs the request dropped first
        cfg.supply_on = 1'b0;
        cyc(2);
        check({6'h00, rst_low, conv_en}, 8'h00);
        cfg.supply_on = 1'b1;
        wait_conv(1'b1);
    endtask

    // Reset, then scenarios in turn
    initial
    begin
        nrst = 1'b0;
        status_rd = 1'b0;
        cfg = '0;
        mon = '0;
        mon.card_present = 1'b1;
        {hi_gnd, lo_gnd} = 2'b00;
        mismatches = 0;
        n_checks = 0;
        cyc(4);
        check(status, STATUS_RESET);
        check({5'h00, int_n, conv_en, clk_o}, 8'h04);
        nrst = 1'b1;
        cyc(2);
        check({7'h00, int_n}, 8'h01);
        read_status();
        s_aux();
        s_clock();
        s_low();
        s_ovld();
        test_done();
    end
endmodule
